// ---- design/adc_seq_regs.vh ----
// Constants for the converter sequencer control block
`ifndef ADC_SEQ_REGS_VH
`define ADC_SEQ_REGS_VH

`define ADDR_PIN_ENABLE 3'h0
`define ADDR_RESULT_HIGH 3'h1
`define ADDR_RESULT_LOW 3'h2
`define ADDR_SETUP 3'h3
`define ADDR_STATUS 3'h4

`define SETUP_RESET 8'h00
`define STATUS_RESET 8'h00
`define PIN_RESET 8'h00

`define SETUP_PU_BIT 7
`define SETUP_JUST_BIT 6
`define SETUP_RES_BIT 5
`define SETUP_SGN_BIT 4
`define SETUP_PRS_HI 3
`define SETUP_PRS_LO 0

`define STAT_DONE_BIT 7
`define STAT_IE_BIT 6
`define STAT_CONT_BIT 5
`define STAT_CH_HI 4
`define STAT_CH_LO 0

`define CONV_CYCLES_8 5'h11
`define CONV_CYCLES_10 5'h14

`endif

// ---- design/adc_sequencer_control.v ----
// Converter sequencer control: registers, conversion timing and results
//
// Local design decisions: the register addresses and the plain strobed port.
`include "adc_seq_regs.vh"
`timescale 1ns/1ns
`default_nettype none
module adc_sequencer_control #(
    parameter N_PINS = 8
) (
    input wire core_clk_i,
    input wire rst_n_i,
    input wire [2:0] addr_i,
    input wire [7:0] wdata_i,
    input wire wr_i,
    input wire rd_i,
    output reg [7:0] rdata_o,
    input wire [9:0] sample_i,
    output reg [N_PINS-1:0] pin_use_bits_o,
    output reg [2:0] channel_o,
    output reg sample_o,
    output reg conv_active_o,
    output reg irq_o
);
    ////////////////////////////////////////////////////////////////
    localparam ST_IDLE = 2'h0;
    localparam ST_CONV = 2'h1;
    localparam ST_DONE = 2'h2;

    reg [7:0] setup_q;
    reg ie_q;
    reg cont_q;
    reg [4:0] ch_q;
    reg done_q;
    reg [7:0] res_hi_q;
    reg [7:0] res_lo_q;
    reg [1:0] state_q;
    reg [4:0] ccnt_q;
    reg [9:0] samp_s1_q;
    reg [9:0] samp_s2_q;
    wire tick;
    wire [7:0] fmt_hi;
    wire [7:0] fmt_lo;

    wire pu = setup_q[`SETUP_PU_BIT];
    wire resolution_select = setup_q[`SETUP_RES_BIT];
    wire wr_pin = wr_i && addr_i == `ADDR_PIN_ENABLE;
    wire wr_setup = wr_i && addr_i == `ADDR_SETUP;
    wire wr_stat = wr_i && addr_i == `ADDR_STATUS;
    wire rd_res = rd_i && (addr_i == `ADDR_RESULT_HIGH || addr_i == `ADDR_RESULT_LOW);
    wire abort = wr_pin || wr_setup;
    wire [4:0] conv_len = resolution_select ? `CONV_CYCLES_8 : `CONV_CYCLES_10;
    wire finish = state_q == ST_CONV && tick && ccnt_q == conv_len;

    conv_clock_div #(.PRS_W(4)) u_div (
        .core_clk_i(core_clk_i),
        .rst_n_i(rst_n_i),
        .run_i(state_q == ST_CONV),
        .prescale_i(setup_q[`SETUP_PRS_HI:`SETUP_PRS_LO]),
        .tick_o(tick)
    );

    result_format u_fmt (
        .sample_i(samp_s2_q),
        .resolution_select_i(resolution_select),
        .left_i(setup_q[`SETUP_JUST_BIT]),
        .signed_i(setup_q[`SETUP_SGN_BIT]),
        .high_o(fmt_hi),
        .low_o(fmt_lo)
    );

    ////////////////////////////////////////////////////////////////
    // Analog sample comes from the converter core, outside this clock
    always @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            samp_s1_q <= 10'h000;
            samp_s2_q <= 10'h000;
        end else begin
            samp_s1_q <= sample_i;
            samp_s2_q <= samp_s1_q;
        end
    end

    ////////////////////////////////////////////////////////////////
    always @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            setup_q <= `SETUP_RESET;
            pin_use_bits_o <= {N_PINS{1'b0}};
            ie_q <= 1'b0;
            cont_q <= 1'b0;
            ch_q <= 5'h00;
        end else begin
            if (wr_pin) begin
                pin_use_bits_o <= wdata_i[N_PINS-1:0];
            end
            if (wr_setup) begin
                setup_q <= wdata_i;
            end
            if (wr_stat) begin
                ie_q <= wdata_i[`STAT_IE_BIT];
                cont_q <= wdata_i[`STAT_CONT_BIT];
                ch_q <= wdata_i[`STAT_CH_HI:`STAT_CH_LO];
            end
        end
    end

    ////////////////////////////////////////////////////////////////
    always @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state_q <= ST_IDLE;
            ccnt_q <= 5'h00;
        end else if (!pu || abort) begin
            state_q <= ST_IDLE;
            ccnt_q <= 5'h00;
        end else if (wr_stat) begin
            state_q <= ST_CONV;
            ccnt_q <= 5'h00;
        end else begin
            case (state_q)
                ST_CONV: begin
                    if (finish) begin
                        state_q <= cont_q ? ST_CONV : ST_DONE;
                        ccnt_q <= 5'h00;
                    end else if (tick) begin
                        ccnt_q <= ccnt_q + 5'h01;
                    end
                end
                ST_DONE: state_q <= ST_IDLE;
                ST_IDLE: state_q <= ST_IDLE;
                default: state_q <= ST_IDLE;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////
    always @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            done_q <= 1'b0;
            res_hi_q <= 8'h00;
            res_lo_q <= 8'h00;
        end else begin
            if (finish && pu && !abort && !wr_stat) begin
                done_q <= 1'b1;
                res_hi_q <= fmt_hi;
                res_lo_q <= fmt_lo;
            end else if (rd_res) begin
                done_q <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////
    always @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rdata_o <= 8'h00;
            irq_o <= 1'b0;
            channel_o <= 3'h0;
            sample_o <= 1'b0;
            conv_active_o <= 1'b0;
        end else begin
            irq_o <= done_q && ie_q;
            channel_o <= ch_q[2:0];
            sample_o <= state_q == ST_CONV && tick && ccnt_q == 5'h00;
            conv_active_o <= state_q == ST_CONV;
            if (rd_i) begin
                case (addr_i)
                    `ADDR_PIN_ENABLE: rdata_o <= pin_use_bits_o;
                    `ADDR_RESULT_HIGH: rdata_o <= res_hi_q;
                    `ADDR_RESULT_LOW: rdata_o <= res_lo_q;
                    `ADDR_SETUP: rdata_o <= setup_q;
                    `ADDR_STATUS: rdata_o <= {done_q, ie_q, cont_q, ch_q};
                    default: rdata_o <= 8'h00;
                endcase
            end else begin
                rdata_o <= 8'h00;
            end
        end
    end
endmodule // adc_sequencer_control
`default_nettype wire

// ---- design/conv_clock_div.v ----
// Conversion clock tick generator dividing the bus clock
`timescale 1ns/1ns
`default_nettype none
module conv_clock_div #(
    parameter PRS_W = 4
) (
    input wire core_clk_i,
    input wire rst_n_i,
    input wire run_i,
    input wire [PRS_W-1:0] prescale_i,
    output reg tick_o
);
    reg [PRS_W:0] cnt_q;
    reg phase_q;
    // One tick per full conversion clock period, 2*(prescale+1) bus cycles
    always @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cnt_q <= {(PRS_W+1){1'b0}};
            phase_q <= 1'b0;
            tick_o <= 1'b0;
        end else if (!run_i) begin
            cnt_q <= {(PRS_W+1){1'b0}};
            phase_q <= 1'b0;
            tick_o <= 1'b0;
        end else if (cnt_q == {1'b0, prescale_i}) begin
            cnt_q <= {(PRS_W+1){1'b0}};
            phase_q <= ~phase_q;
            tick_o <= phase_q;
        end else begin
            cnt_q <= cnt_q + {{PRS_W{1'b0}}, 1'b1};
            tick_o <= 1'b0;
        end
    end
endmodule // conv_clock_div
`default_nettype wire

// ---- design/result_format.v ----
// Result byte packing for resolution, justification and sign
`timescale 1ns/1ns
`default_nettype none
module result_format (
    input wire [9:0] sample_i,
    input wire resolution_select_i,
    input wire left_i,
    input wire signed_i,
    output reg [7:0] high_o,
    output reg [7:0] low_o
);
    reg [9:0] v;
    always @* begin
        v = sample_i;
        if (signed_i) begin
            v[9] = ~sample_i[9];
        end
        if (resolution_select_i) begin
            high_o = 8'h00;
            low_o = signed_i ? {~sample_i[9], sample_i[8:2]} : sample_i[9:2];
        end else if (left_i) begin
            high_o = v[9:2];
            low_o = {v[1:0], 6'h00};
        end else begin
            high_o = {{6{signed_i & v[9]}}, v[9:8]};
            low_o = v[7:0];
        end
    end
endmodule // result_format
`default_nettype wire

// ---- tb/adc_seq_checker_assertions.sv ----
// Assertion checker for the converter sequencer control ports
`timescale 1ns/1ns
`default_nettype none
module adc_seq_checker #(parameter N_PINS = 8) (
    input wire logic core_clk_i,
    input wire logic rst_n_i,
    input wire logic [2:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    input wire logic [7:0] rdata_o,
    input wire logic [9:0] sample_i,
    input wire logic [N_PINS-1:0] pin_use_bits_o,
    input wire logic [2:0] channel_o,
    input wire logic sample_o,
    input wire logic conv_active_o,
    input wire logic irq_o
);
default clocking @(posedge core_clk_i); endclocking
default disable iff (!rst_n_i);
logic [7:0] setup_q;
logic ie_q;
// Shadow of the setup byte and interrupt enable as software wrote them
always @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
        setup_q <= 8'h00;
        ie_q <= 1'b0;
    end else if (wr_i) begin
        setup_q <= (addr_i == 3'h3) ? wdata_i : setup_q;
        ie_q <= (addr_i == 3'h4) ? wdata_i[6] : ie_q;
    end
end
////////////////////////////////////////////////////////////////////////
property p_pin; wr_i && addr_i == 3'h0 |=> pin_use_bits_o == $past(wdata_i[N_PINS-1:0]); endproperty
a_pin: assert property (p_pin) else $error("pin enable not copied");
property p_abort; wr_i && (addr_i == 3'h0 || addr_i == 3'h3) |-> ##[1:3] !conv_active_o; endproperty
a_abort: assert property (p_abort) else $error("conversion not aborted");
property p_start; wr_i && addr_i == 3'h4 && setup_q[7] |-> ##[1:3] conv_active_o; endproperty
a_start: assert property (p_start) else $error("status write did not start");
property p_off; (!setup_q[7]) [*3] |-> !conv_active_o; endproperty
a_off: assert property (p_off) else $error("converting while powered down");
property p_irq; $rose(irq_o) |-> $past(ie_q); endproperty
a_irq: assert property (p_irq) else $error("request while disabled");
property p_clear; rd_i && (addr_i == 3'h1 || addr_i == 3'h2) && !conv_active_o |=> ##1 !irq_o; endproperty
a_clear: assert property (p_clear) else $error("request stays after result read");
property p_chan; wr_i && addr_i == 3'h4 |=> ##1 channel_o == $past(wdata_i[2:0], 2); endproperty
a_chan: assert property (p_chan) else $error("channel not taken");
property p_setup; rd_i && addr_i == 3'h3 |=> rdata_o == setup_q; endproperty
a_setup: assert property (p_setup) else $error("setup read back wrong");
c_start: cover property (wr_i && addr_i == 3'h4 && setup_q[7]);
c_irq: cover property ($rose(irq_o));
c_read: cover property (rd_i && addr_i == 3'h1);
endmodule // adc_seq_checker
bind adc_sequencer_control adc_seq_checker #(.N_PINS(N_PINS)) u_chk (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i),
    .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .sample_i(sample_i),
    .pin_use_bits_o(pin_use_bits_o), .channel_o(channel_o), .sample_o(sample_o),
    .conv_active_o(conv_active_o), .irq_o(irq_o));
`default_nettype wire

// ---- tb/tb.sv ----
// Self-checking bench for the converter sequencer control block
`timescale 1ns/1ns
`default_nettype none
module tb;
logic clk = 1'b0, rst_n = 1'b0, wr = 1'b0, rd = 1'b0;
logic [2:0] addr = 3'h0;
logic [7:0] wdata = 8'h00, d;
logic [9:0] smp = 10'h000;
logic [15:0] e;
wire [7:0] rdata, pins;
wire [2:0] chan;
wire smp_o, act, irq;
int bad_count = 0;
int cmp_count = 0;
always #25 clk = ~clk;
adc_sequencer_control DUT (.core_clk_i(clk), .rst_n_i(rst_n), .addr_i(addr), .wdata_i(wdata), .wr_i(wr),
    .rd_i(rd), .rdata_o(rdata), .sample_i(smp), .pin_use_bits_o(pins), .channel_o(chan), .sample_o(smp_o),
    .conv_active_o(act), .irq_o(irq));
////////////////////////////////////////////////////////////////////////
task stop_test;
    $display("mismatches %0d comparisons %0d", bad_count, cmp_count);
    if (bad_count == 0 && cmp_count > 0) begin
        $display("bench passed");
    end else begin
        $display("bench failed");
    end
    $finish;
endtask
task check(input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
        bad_count++;
        $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
endtask
task wr_reg(input logic [2:0] a, input logic [7:0] v);
    @(posedge clk);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
endtask
task rd_reg(input logic [2:0] a);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    d = rdata;
endtask
task wait_irq;
    int n;
    n = 0;
    while (irq !== 1'b1 && n < 300) begin
        @(posedge clk);
        n++;
    end
    if (irq !== 1'b1) begin
        bad_count++;
        stop_test;
    end
endtask
// Expected {high, low} result bytes for a setup byte and a raw sample
function logic [15:0] fmt(input logic [7:0] s, input logic [9:0] x);
    logic [9:0] v;
    v = s[4] ? (x ^ 10'h200) : x;
    if (s[5]) fmt = {8'h00, v[9:2]};
    else if (s[6]) fmt = {v[9:2], v[1:0], 6'h00};
    else fmt = {{6{s[4] & v[9]}}, v};
endfunction
task conv_case(input logic [7:0] s, input logic [9:0] x);
    wr_reg(3'h3, s);
    smp <= x;
    wr_reg(3'h4, 8'h41);
    wait_irq;
    e = fmt(s, x);
    rd_reg(3'h4);
    check(d, 8'hc1);
    rd_reg(3'h1);
    check(d, e[15:8]);
    rd_reg(3'h2);
    check(d, e[7:0]);
    repeat (100) @(posedge clk);
    check({7'h00, irq}, 8'h00);
endtask
////////////////////////////////////////////////////////////////////////
initial begin
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    wr_reg(3'h0, 8'h02);
    rd_reg(3'h0);
    check(d, 8'h02);
    check(pins, 8'h02);
    conv_case(8'h80, 10'h2c5);
    conv_case(8'hc0, 10'h2c5);
    conv_case(8'ha0, 10'h137);
    conv_case(8'he0, 10'h137);
    conv_case(8'h91, 10'h0c5);
    conv_case(8'hb0, 10'h3f0);
    rd_reg(3'h5);
    check(d, 8'h00);
    wr_reg(3'h4, 8'h67);
    wait_irq;
    check({5'h00, chan}, 8'h07);
    rd_reg(3'h2);
    @(posedge clk);
    @(posedge clk);
    check({7'h00, irq}, 8'h00);
    wait_irq;
    rd_reg(3'h2);
    wr_reg(3'h0, 8'h01);
    repeat (100) @(posedge clk);
    check({7'h00, irq}, 8'h00);
    wr_reg(3'h3, 8'h00);
    wr_reg(3'h4, 8'h41);
    repeat (100) @(posedge clk);
    check({7'h00, irq}, 8'h00);
    rd_reg(3'h4);
    check(d, 8'h41);
    stop_test;
end
endmodule // tb
`default_nettype wire
